// >>> pbcsb_defines.svh
`ifndef PBCSB_DEFINES_SVH
`define PBCSB_DEFINES_SVH
// Summary of operation
// R1: Data passes both directions bit-exact.
// R2: Control bits C0, C1 forwarded unchanged.
// R3: Cache register window asserts select, bits 3:1.
// R4: Relocate only when control bit 5 set.
// R5: Read/pause and write/byte treated alike.
// R6: Address bit zero forwarded unchanged.
// R7: Limits check bits 17:13; valid address output.
// R8: Master sync on valid address sets request.
// R9: Cache acknowledge clears the request flag.
// R10: Drive enable rises with the request.
// R11: Memory or register address given to cache.
// R12: Cache accepts write data then signals done.
// R13: Read data chosen by register select.
// R14: Read data held on done rising edge.
// R15: Held data drives bus when not map access.
// R16: Done falling edge sets slave sync flag.
// R17: Master sync negation drops drive enable.
// R18: Parity latched with data, gated C1, limits.
// R19: Parity line only with flag and enable.
// R20: Cache timeout blocks slave sync this cycle.
// R21: Thirty-two 21-bit map registers, 64 addresses.
// R22: High half bits 21:16, low 15:01.
// R23: Outside limits and register window, no request to cache.
// R24: Map register plus bits 12:1 forms address.
// R25: Disabled relocation zeroes bits 21:18.
// R26: Reset clears request, sync, timeout, parity flags.
`define PBCSB_CREG_LO 18'o777740
`define PBCSB_CREG_HI 18'o777752
`define PBCSB_MAP_LO 18'o770200
`define PBCSB_MAP_HI 18'o770376
`define PBCSB_RELOC_BIT 5
`define PBCSB_MAP_DELAY_NS 70
`define PBCSB_CLK_NS 100
`define PBCSB_MAP_DELAY_CYC ((`PBCSB_MAP_DELAY_NS + `PBCSB_CLK_NS - 1) / `PBCSB_CLK_NS)
`endif

// >>> pbcsb_pkg.sv
package pbcsb_pkg;
  typedef struct packed {
    logic c1;
    logic c0;
    logic [17:0] addr;
    logic [15:0] data;
  } pbcsb_bus_req_t;
  typedef enum logic [1:0] {PBCSB_IDLE, PBCSB_WAIT, PBCSB_DONE} pbcsb_state_t;
endpackage

// >>> pbcsb_bridge.sv
`timescale 1ns/1ns
`include "pbcsb_defines.svh"
module pbcsb_bridge
  import pbcsb_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic BUS_MSYN,
  input wire logic BUS_C0,
  input wire logic BUS_C1,
  input wire logic [17:0] BUS_ADDR,
  input wire logic [15:0] BUS_DATA_IN,
  input wire logic [4:0] UPPER_LIMIT,
  input wire logic [4:0] LOWER_LIMIT,
  input wire logic RELOCATION_ENABLE,
  input wire logic CACHE_ACK,
  input wire logic CACHE_DONE,
  input wire logic CACHE_TIMEOUT,
  input wire logic CACHE_BAD_PARITY,
  input wire logic [15:0] MEMORY_READ_DATA,
  input wire logic [15:0] CACHE_REGISTER_DATA,
  output logic [15:0] BUS_DATA_OUT,
  output logic BUS_DATA_OE_N,
  output logic BUS_SSYN,
  output logic BUS_PB,
  output logic BUS_REQUEST_FLAG,
  output logic VALID_CACHE_ADDRESS,
  output logic CACHE_REG_SELECT,
  output logic [21:0] CACHE_ADDR,
  output logic [2:0] CACHE_REG_ADDR,
  output logic CACHE_C0,
  output logic CACHE_C1,
  output logic [15:0] CACHE_WDATA,
  output logic PARITY_FLAG_OUT
);
  // Handshake inputs come from another domain: three stages, change accepted when the last two agree.
  // Order in the filtered vector: master sync, cache done, cache timeout, cache acknowledge.
  localparam int N_SYNC = 4;
  logic [N_SYNC-1:0] async_in;
  logic [N_SYNC-1:0] async_filt;
  logic msyn;
  logic done;
  logic tmo;
  logic ack;
  logic done_q;
  pbcsb_bus_req_t req;
  logic [20:0] map_mem [0:31];
  logic [4:0] reg_cnt;
  logic map_written;
  logic par_latch;
  logic ssyn_flag;
  logic tmo_flag;
  logic enbus;
  logic [15:0] read_data_hold;
  logic in_limits;
  logic creg_hit;
  logic map_hit;
  logic valid_addr;
  logic [4:0] map_idx;
  logic [20:0] map_entry;
  logic [21:0] reloc_addr;
  logic [15:0] map_rdata;
  logic [15:0] next_bus_data;
  logic done_rise;
  logic done_fall;
  logic map_ready;
  logic par_flag;

  assign async_in = {CACHE_ACK, CACHE_TIMEOUT, CACHE_DONE, BUS_MSYN};

  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi++)
    begin : g_sync
      logic [2:0] stage;
      logic filt;
      always_ff @(posedge SYS_CLK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          stage <= 3'h0;
          filt <= 1'b0;
        end
        else
        begin
          stage <= {stage[1:0], async_in[gi]};
          // A single disagreeing sample is a glitch or a late edge and leaves the level alone.
          if (stage[1] == stage[2])
            filt <= stage[2];
        end
      end
      assign async_filt[gi] = filt;
    end
  endgenerate

  assign msyn = async_filt[0];
  assign done = async_filt[1];
  assign tmo = async_filt[2];
  assign ack = async_filt[3];

  // One inclusive compare serves both the cache register window and the map register block.
  function automatic logic in_window(input logic [17:0] a, input logic [17:0] lo, input logic [17:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Address and data are held stable by the master while sync is asserted.
  assign req = '{c1: BUS_C1, c0: BUS_C0, addr: BUS_ADDR, data: BUS_DATA_IN};
  assign creg_hit = in_window(req.addr, `PBCSB_CREG_LO, `PBCSB_CREG_HI); // [R3]
  assign map_hit = in_window(req.addr, `PBCSB_MAP_LO, `PBCSB_MAP_HI); // [R21]
  assign in_limits = (req.addr[17:13] < UPPER_LIMIT) && (req.addr[17:13] >= LOWER_LIMIT); // [R7] [R23]
  assign valid_addr = in_limits || creg_hit; // [R7]
  assign map_idx = map_hit ? req.addr[6:2] : req.addr[17:13];
  assign map_entry = map_mem[map_idx];
  // Relocation adds the entry (bits 21:1) to bits 12:1; disabled passes with 21:18 at zero.
  assign reloc_addr = RELOCATION_ENABLE
    ? {map_entry + {9'h000, req.addr[12:1]}, req.addr[0]} // [R4] [R24] [R6]
    : {4'h0, req.addr}; // [R25] [R6]
  // Low half holds bits 15:1 with bit 0 read as zero; high half reads bits 21:16.
  assign map_rdata = req.addr[1] ? {10'h000, map_entry[20:15]} : {map_entry[14:0], 1'b0}; // [R22]
  assign next_bus_data = map_hit ? map_rdata : read_data_hold; // [R15]
  assign done_rise = done && !done_q;
  assign done_fall = !done && done_q;
  assign map_ready = map_hit && msyn && (reg_cnt == 5'(`PBCSB_MAP_DELAY_CYC));
  assign par_flag = par_latch && !req.c1 && in_limits; // [R18]

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      done_q <= 1'b0;
      reg_cnt <= 5'h00;
      map_written <= 1'b0;
    end
    else
    begin
      done_q <= done;
      if (!msyn || !map_hit)
        reg_cnt <= 5'h00;
      else if (reg_cnt != 5'(`PBCSB_MAP_DELAY_CYC))
        reg_cnt <= reg_cnt + 5'h01;
      map_written <= map_hit && msyn;
    end
  end

  // Map entries are undefined at power-up, so they carry no reset.
  always_ff @(posedge SYS_CLK)
  begin
    if (map_hit && msyn && !map_written && req.c1)
    begin
      if (req.addr[1])
        map_mem[map_idx][20:15] <= req.data[5:0]; // [R21] [R22]
      else
        map_mem[map_idx][14:0] <= req.data[15:1]; // [R22]
    end
  end

  // Set wins over clear; enbus keeps the request from rising again after the acknowledge.
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      BUS_REQUEST_FLAG <= 1'b0; // [R26]
    else if (msyn && valid_addr && !enbus)
      BUS_REQUEST_FLAG <= 1'b1; // [R8]
    else if (ack)
      BUS_REQUEST_FLAG <= 1'b0; // [R9]
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      enbus <= 1'b0;
    else if (!msyn)
      enbus <= 1'b0; // [R17]
    else if ((valid_addr && !ack) || map_hit)
      enbus <= 1'b1; // [R10]
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      read_data_hold <= 16'h0000;
      par_latch <= 1'b0; // [R26]
    end
    else if (done_rise)
    begin
      read_data_hold <= CACHE_REG_SELECT ? CACHE_REGISTER_DATA : MEMORY_READ_DATA; // [R13] [R14]
      par_latch <= CACHE_BAD_PARITY; // [R18]
    end
    else if (!msyn)
    begin
      read_data_hold <= 16'h0000;
      par_latch <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      ssyn_flag <= 1'b0; // [R26]
    else if (done_fall || map_ready)
      ssyn_flag <= 1'b1; // [R16]
    else if (!msyn)
      ssyn_flag <= 1'b0;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      tmo_flag <= 1'b0; // [R26]
    else if (tmo)
      tmo_flag <= 1'b1; // [R20]
    else if (!msyn)
      tmo_flag <= 1'b0;
  end

  // Every output has its own register so that no pin is driven through logic.
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      BUS_DATA_OUT <= 16'h0000;
    end
    else
    begin
      BUS_DATA_OUT <= next_bus_data; // [R1] [R15]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      BUS_DATA_OE_N <= 1'b1;
    end
    else
    begin
      BUS_DATA_OE_N <= !(enbus && msyn && !req.c1); // [R15] [R17]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      BUS_SSYN <= 1'b0;
    end
    else
    begin
      BUS_SSYN <= enbus && msyn && ssyn_flag && !tmo_flag && !tmo; // [R16] [R20] [R17]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      BUS_PB <= 1'b0;
    end
    else
    begin
      BUS_PB <= par_flag && enbus && msyn; // [R19]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      VALID_CACHE_ADDRESS <= 1'b0;
    end
    else
    begin
      VALID_CACHE_ADDRESS <= valid_addr; // [R7]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CACHE_REG_SELECT <= 1'b0;
    end
    else
    begin
      CACHE_REG_SELECT <= creg_hit; // [R3]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CACHE_ADDR <= 22'h000000;
    end
    else
    begin
      CACHE_ADDR <= reloc_addr; // [R11]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CACHE_REG_ADDR <= 3'h0;
    end
    else
    begin
      CACHE_REG_ADDR <= req.addr[3:1]; // [R3] [R11]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CACHE_C0 <= 1'b0;
    end
    else
    begin
      CACHE_C0 <= req.c0; // [R2] [R5]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CACHE_C1 <= 1'b0;
    end
    else
    begin
      CACHE_C1 <= req.c1; // [R2]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CACHE_WDATA <= 16'h0000;
    end
    else
    begin
      CACHE_WDATA <= req.data; // [R1] [R12]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PARITY_FLAG_OUT <= 1'b0;
    end
    else
    begin
      PARITY_FLAG_OUT <= par_flag; // [R18]
    end
  end
endmodule

// >>> pbcsb_chk.sv
`timescale 1ns/1ns
module pbcsb_chk (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic BUS_MSYN,
  input wire logic BUS_C1,
  input wire logic [17:0] BUS_ADDR,
  input wire logic RELOCATION_ENABLE,
  input wire logic CACHE_ACK,
  input wire logic CACHE_TIMEOUT,
  input wire logic BUS_SSYN,
  input wire logic BUS_PB,
  input wire logic BUS_REQUEST_FLAG,
  input wire logic VALID_CACHE_ADDRESS,
  input wire logic CACHE_REG_SELECT,
  input wire logic [21:0] CACHE_ADDR,
  input wire logic CACHE_C1,
  input wire logic PARITY_FLAG_OUT
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_acked;
    BUS_REQUEST_FLAG && CACHE_ACK;
  endsequence
  chk_ack_clears_req: assert property (s_acked |-> ##[1:6] !BUS_REQUEST_FLAG)
    else $error("request not cleared by acknowledge");
  chk_req_needs_valid: assert property ($rose(BUS_REQUEST_FLAG) |-> VALID_CACHE_ADDRESS)
    else $error("request without valid address");
  chk_ssyn_drops: assert property ($fell(BUS_MSYN) |-> ##[1:6] !BUS_SSYN)
    else $error("slave sync stays after master sync drop");
  chk_timeout_blocks: assert property ($rose(CACHE_TIMEOUT) |-> !BUS_SSYN [*8])
    else $error("slave sync after timeout");
  chk_pb_gated: assert property (BUS_PB |-> PARITY_FLAG_OUT)
    else $error("parity line without parity flag");
  chk_reg_window: assert property (CACHE_REG_SELECT == ($past(BUS_ADDR) >= 18'o777740 && $past(BUS_ADDR) <= 18'o777752))
    else $error("register select mismatch");
  chk_addr_pass: assert property (!$past(RELOCATION_ENABLE) |-> CACHE_ADDR == {4'h0, $past(BUS_ADDR)})
    else $error("unrelocated address mismatch");
  chk_ctl_pass: assert property (CACHE_C1 == $past(BUS_C1))
    else $error("control bit mismatch");
endmodule
bind pbcsb_bridge pbcsb_chk u_pbcsb_chk (.*);

// >>> pbcsb_cache_model.sv
`timescale 1ns/1ns
module pbcsb_cache_model #(
  parameter logic [15:0] MD = 16'h5a3c,
  parameter logic [15:0] RD = 16'hc3a5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic msyn,
  input wire logic req,
  input wire logic par_m,
  input wire logic tmo_m,
  output logic ack,
  output logic done,
  output logic tmo,
  output logic bad_par,
  output logic [15:0] mdata,
  output logic [15:0] rdata
);
  logic [2:0] cnt;
  // Done is held six cycles, not 60 ns, so the bridge's input filter can see it.
  assign done = !tmo_m && cnt != 3'h0 && cnt != 3'h7;
  assign tmo = tmo_m && cnt != 3'h0;
  // Data is inverted outside done so a late capture is caught.
  assign mdata = done ? MD : ~MD;
  assign rdata = done ? RD : ~RD;
  assign bad_par = done & par_m;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ack <= 1'b0;
      cnt <= 3'h0;
    end
    else if (!msyn)
    begin
      ack <= 1'b0;
      cnt <= 3'h0;
    end
    else
    begin
      if (req)
        ack <= 1'b1;
      if (ack && !req && cnt == 3'h0)
        cnt <= 3'h1;
      else if (cnt != 3'h0 && cnt != 3'h7)
        cnt <= cnt + 3'h1;
    end
endmodule

// >>> pbcsb_bridge_tb_top.sv
`timescale 1ns/1ns
module pbcsb_bridge_tb_top;
  localparam logic [15:0] MD = 16'h5a3c;
  localparam logic [15:0] RD = 16'hc3a5;
  logic SYS_CLK, RST_N, BUS_MSYN, BUS_C0, BUS_C1, RELOCATION_ENABLE, par_m, tmo_m, BUS_DATA_OE_N;
  logic CACHE_ACK, CACHE_DONE, CACHE_TIMEOUT, CACHE_BAD_PARITY, BUS_SSYN, BUS_PB, BUS_REQUEST_FLAG;
  logic VALID_CACHE_ADDRESS, CACHE_REG_SELECT, CACHE_C0, CACHE_C1, PARITY_FLAG_OUT;
  logic [17:0] BUS_ADDR;
  logic [15:0] BUS_DATA_IN, MEMORY_READ_DATA, CACHE_REGISTER_DATA, BUS_DATA_OUT, CACHE_WDATA;
  logic [4:0] UPPER_LIMIT, LOWER_LIMIT;
  logic [21:0] CACHE_ADDR, ca;
  logic [2:0] CACHE_REG_ADDR;
  int n_errors, n_checks;
  pbcsb_bridge u_pbcsb_bridge (.*);
  pbcsb_cache_model #(.MD(MD), .RD(RD)) u_pbcsb_cache_model (.clk(SYS_CLK), .rst_n(RST_N), .msyn(BUS_MSYN),
    .req(BUS_REQUEST_FLAG), .par_m(par_m), .tmo_m(tmo_m), .ack(CACHE_ACK), .done(CACHE_DONE),
    .tmo(CACHE_TIMEOUT), .bad_par(CACHE_BAD_PARITY), .mdata(MEMORY_READ_DATA), .rdata(CACHE_REGISTER_DATA));
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [21:0] e, input logic [21:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic c1, input logic [17:0] a, input logic [15:0] d, input logic es,
    input logic [15:0] ed, input logic ep);
    int i;
    @(posedge SYS_CLK);
    BUS_C1 <= c1;
    BUS_ADDR <= a;
    BUS_DATA_IN <= d;
    BUS_MSYN <= 1'b1;
    for (i = 0; i < 60 && BUS_SSYN !== 1'b1; i++)
      @(negedge SYS_CLK);
    chk("ssyn", es, BUS_SSYN);
    chk("c0", BUS_C0, CACHE_C0);
    chk("wdata", d, CACHE_WDATA);
    chk("reg_addr", a[3:1], CACHE_REG_ADDR);
    ca = CACHE_ADDR;
    if (es)
      chk("oe_n", c1, BUS_DATA_OE_N);
    if (es && !c1)
    begin
      chk("data", ed, BUS_DATA_OUT);
      chk("pb", ep, BUS_PB);
      chk("par_flag", ep, PARITY_FLAG_OUT);
    end
    @(posedge SYS_CLK);
    BUS_MSYN <= 1'b0;
    repeat (10) @(negedge SYS_CLK);
    chk("ssyn_end", 0, BUS_SSYN);
    @(posedge SYS_CLK);
  endtask
  initial
  begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  initial
  begin
    repeat (4000) @(posedge SYS_CLK);
    n_errors++;
    wrap_up;
  end
  initial
  begin
    {BUS_MSYN, BUS_C0, BUS_C1, RELOCATION_ENABLE, par_m, tmo_m} = 6'h00;
    BUS_ADDR = 18'h00000;
    BUS_DATA_IN = 16'h0000;
    UPPER_LIMIT = 5'h10;
    LOWER_LIMIT = 5'h01;
    RST_N = 1'b0;
    repeat (4) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    xfer(0, 18'o020000, 16'h0000, 1, MD, 0);
    BUS_C0 <= 1'b1;
    xfer(1, 18'o040003, 16'h1234, 1, 16'h0000, 0);
    chk("addr", {4'h0, 18'o040003}, ca);
    BUS_C0 <= 1'b0;
    xfer(0, 18'o777744, 16'h0000, 1, RD, 0);
    xfer(0, 18'o000100, 16'h0000, 0, 16'h0000, 0);
    xfer(0, 18'o400000, 16'h0000, 0, 16'h0000, 0);
    par_m <= 1'b1;
    xfer(0, 18'o020000, 16'h0000, 1, MD, 1);
    par_m <= 1'b0;
    tmo_m <= 1'b1;
    xfer(0, 18'o020000, 16'h0000, 0, 16'h0000, 0);
    tmo_m <= 1'b0;
    xfer(1, 18'o770204, 16'h0401, 1, 16'h0000, 0);
    xfer(1, 18'o770206, 16'hffc3, 1, 16'h0000, 0);
    xfer(0, 18'o770204, 16'h0000, 1, 16'h0400, 0);
    xfer(0, 18'o770206, 16'h0000, 1, 16'h0003, 0);
    RELOCATION_ENABLE <= 1'b1;
    xfer(0, 18'o020007, 16'h0000, 1, MD, 0);
    chk("reloc", 22'h030407, ca);
    wrap_up;
  end
endmodule
